// ---- typec_attach_indicator_outputs.v ----
// Type-C attach classification to indicator and control pins, with an AXI4-Lite register view.
//
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
`include "attach_indicator_regs.vh"
module typec_attach_indicator_outputs (
  input  wire        aclk,
  input  wire        aresetn,
  // Pin side inputs, all asynchronous to aclk.
  input  wire        enable,
  input  wire        overcurrent_in_n,
  input  wire        vbus_level_monitor,
  input  wire        vbus_valid,
  input  wire [1:0]  profile_sel,
  input  wire [1:0]  cc1_class,
  input  wire [1:0]  cc2_class,
  // Push-pull outputs.
  output reg         vbus_supply_enable,
  output reg         audio_adapter,
  output reg         fault_latched_out,
  // Open-drain outputs: the pin is pulled low while its enable is high.
  output reg         plug_orientation_n_oe,
  output reg         cable_power_cc1_n_oe,
  output reg         cable_power_cc2_n_oe,
  output reg         connected_n_oe,
  output reg         default_current_ind_n_oe,
  output reg         medium_current_ind_n_oe,
  output reg         high_current_ind_n_oe,
  // AXI4-Lite slave.
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);

  // Synchronised copies of the pin inputs.
  wire [`AIR_PIN_W-1:0] pins_sync;  // Packed synchroniser output.
  wire        enable_s;         // Enable level.
  wire        overcurrent_n_s;  // Overcurrent input, low active.
  wire        ovp_s;            // VBUS monitor above its limit.
  wire        vbus_ok_s;        // VBUS in valid range.
  wire [1:0]  profile_s;        // Current profile select code.
  wire [1:0]  cc1_s;            // CC1 classification.
  wire [1:0]  cc2_s;            // CC2 classification.

  // Every pin passes two flops before use; idle levels are enable low, fault input high.
  // The levels on these pins come from other parts of the board with no common clock.
  // A two-bit code may show a mix of old and new bits for one cycle, so an output
  // may follow such a code for one cycle before it settles.
  pin_sync #(
    .WIDTH       (`AIR_PIN_W)
  ) u_pin_sync (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .async_in    ({enable,              // Bit 10.
                   overcurrent_in_n,    // Bit 9.
                   vbus_level_monitor,  // Bit 8.
                   vbus_valid,          // Bit 7.
                   profile_sel,         // Bits 6 to 5.
                   cc1_class,           // Bits 4 to 3.
                   cc2_class,           // Bits 2 to 1.
                   1'b0}),              // Bit 0, padding.
    .reset_value (`AIR_PIN_IDLE),
    .sync_out    (pins_sync)
  );

  // Unpack the synchronised word, most significant field first.
  assign enable_s  = pins_sync[10];
  assign overcurrent_n_s = pins_sync[9];
  assign ovp_s     = pins_sync[8];
  assign vbus_ok_s = pins_sync[7];
  assign profile_s = pins_sync[6:5];
  assign cc1_s     = pins_sync[4:3];
  assign cc2_s     = pins_sync[2:1];
  // Bit 0 is unused padding kept so the reset pattern stays readable.

  // Role capture and fault state.
  reg  [1:0]  settle_reg;       // Counts cycles until synchronised pins are valid.
  reg         role_ok_reg;      // Role has been latched.
  reg         upstream_reg;     // Latched role: high for upstream facing.
  reg         enable_d_reg;     // Previous enable level for toggle detection.
  reg         fault_reg;        // Latched fault flag.
  reg         hold_reg;         // Software hold: forces the role outputs inactive.

  // Live fault condition from overcurrent or overvoltage.
  wire fault_now = ~overcurrent_n_s | ovp_s;
  // Any change of the enable level counts as a toggle.
  wire enable_toggle = enable_s ^ enable_d_reg;

  // The settle count lets both synchroniser stages fill with real pin levels, so the
  // role is never taken from the reset pattern of the profile bits.
  // The role is latched once after reset and never changes until the next reset.
  always @(posedge aclk) begin
    if (!aresetn) begin
      settle_reg   <= 2'h0;
      role_ok_reg  <= 1'b0;
      upstream_reg <= 1'b0;
    end else if (!role_ok_reg) begin
      if (settle_reg == `AIR_SETTLE_CYCLES) begin
        role_ok_reg  <= 1'b1;
        upstream_reg <= (profile_s == `PROF_UPSTREAM);
      end else begin
        // Still settling: count one more cycle.
        settle_reg <= settle_reg + 2'h1;
      end
    end
  end

  // Fault flag: a new fault wins over a clearing toggle in the same cycle.
  // The flag clears on a change of the enable level in either direction; an enable
  // pin that simply stays low or high never clears it.
  always @(posedge aclk) begin
    if (!aresetn) begin
      enable_d_reg <= 1'b0;
      fault_reg    <= 1'b0;
    end else begin
      // Remember the enable level to spot a change in the next cycle.
      enable_d_reg <= enable_s;
      if (fault_now) begin
        fault_reg <= 1'b1;
      end else if (enable_toggle) begin
        fault_reg <= 1'b0;
      end
    end
  end

  // Attachment classification from both lines, re-evaluated every cycle.
  // A line that shows the cable load is only powered when the other line carries
  // the sink, so a cable load alone never switches cable power on.
  // In the sink role the same two bits per line carry the advertised current.
  reg dn_attached;     // Exactly one line shows a sink.
  reg dn_flipped;      // The sink sits on CC2.
  reg dn_audio;        // Both lines show the cable load: audio accessory.
  reg dn_vconn1;       // Cable load on CC1 with sink on CC2.
  reg dn_vconn2;       // Cable load on CC2 with sink on CC1.
  reg [1:0] up_adv;    // Advertised current on the active line.
  reg up_attached;     // One line advertises a source and VBUS is valid.

  // Decode the two classifications for both roles.
  always @* begin
    dn_attached = (cc1_s == `CC_SINK_RD) ^ (cc2_s == `CC_SINK_RD);
    dn_flipped  = dn_attached && (cc2_s == `CC_SINK_RD);
    dn_audio    = (cc1_s == `CC_CABLE_RA) && (cc2_s == `CC_CABLE_RA);
    dn_vconn1   = dn_attached && dn_flipped && (cc1_s == `CC_CABLE_RA);
    dn_vconn2   = dn_attached && !dn_flipped && (cc2_s == `CC_CABLE_RA);
    // Only one line may carry an advert; two at once is not a valid attach.
    if (cc1_s != `CC_ADV_NONE && cc2_s == `CC_ADV_NONE) begin
      up_adv = cc1_s;
    end else if (cc2_s != `CC_ADV_NONE && cc1_s == `CC_ADV_NONE) begin
      up_adv = cc2_s;
    end else begin
      // No advert, or both lines advertising: treated as not attached.
      up_adv = `CC_ADV_NONE;
    end
    up_attached = (up_adv != `CC_ADV_NONE) && vbus_ok_s;
  end

  // The gate uses the live fault, not the flag, so the pins come back as soon as
  // the fault input is released while the fault indicator stays set.
  // Role outputs may be active only when enabled, fault free, role known and not held.
  wire run = role_ok_reg && enable_s && !fault_now && !hold_reg;
  wire run_dn = run && !upstream_reg;
  wire run_up = run && upstream_reg;

  // Every pin comes from a flop, so decode glitches within a cycle never reach
  // the board switches.
  // Registered pin outputs.
  always @(posedge aclk) begin
    if (!aresetn) begin
      // All pins released and the indicators low while in reset.
      vbus_supply_enable       <= 1'b0;
      audio_adapter            <= 1'b0;
      fault_latched_out        <= 1'b0;
      plug_orientation_n_oe    <= 1'b0;
      cable_power_cc1_n_oe     <= 1'b0;
      cable_power_cc2_n_oe     <= 1'b0;
      connected_n_oe           <= 1'b0;
      default_current_ind_n_oe <= 1'b0;
      medium_current_ind_n_oe  <= 1'b0;
      high_current_ind_n_oe    <= 1'b0;
    end else begin
      // The fault indicator follows the flag, including the cycle a fault arrives.
      fault_latched_out        <= fault_reg | fault_now;
      // Source role outputs.
      vbus_supply_enable       <= run_dn && dn_attached;
      plug_orientation_n_oe    <= run_dn && dn_flipped;
      cable_power_cc1_n_oe     <= run_dn && dn_vconn1;
      cable_power_cc2_n_oe     <= run_dn && dn_vconn2;
      audio_adapter            <= run_dn && dn_audio;
      // Sink role outputs.
      connected_n_oe           <= run_up && up_attached;
      // The advert code selects one indicator, so at most one is active.
      default_current_ind_n_oe <= run_up && up_attached
                                  && (up_adv == `CC_ADV_DEFAULT);
      medium_current_ind_n_oe  <= run_up && up_attached
                                  && (up_adv == `CC_ADV_MEDIUM);
      high_current_ind_n_oe    <= run_up && up_attached
                                  && (up_adv == `CC_ADV_HIGH);
    end
  end

  // AXI4-Lite write path: address and data are taken in either order.
  // The ready signals drop while a channel is held or a response waits, so a
  // second write cannot overtake the first.
  // Only the low address bits are decoded; higher bits alias onto the same words.
  reg        aw_full_reg;                // Write address held.
  reg        w_full_reg;                 // Write data held.
  reg [3:0]  aw_addr_reg;                // Held write address bits.
  reg [31:0] w_data_reg;                 // Held write data.
  reg [3:0]  w_strb_reg;                 // Held byte strobes.

  assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_full_reg && !s_axi_bvalid;

  // Capture each write channel, then commit when both are present.
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg  <= 1'b0;
      w_full_reg   <= 1'b0;
      aw_addr_reg  <= 4'h0;
      w_data_reg   <= 32'h0000_0000;
      w_strb_reg   <= 4'h0;
      hold_reg     <= `AIR_CTRL_RESET;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `AXI_RESP_OKAY;
    end else begin
      // Address channel.
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr[`AIR_ADDR_W-1:0];
      end
      // Data channel.
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (aw_full_reg && w_full_reg) begin
        // Both halves present: perform the write and raise the response.
        aw_full_reg  <= 1'b0;
        w_full_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr_reg == `AIR_CTRL_ADDR) begin
          s_axi_bresp <= `AXI_RESP_OKAY;
          // Byte lane zero carries the hold bit; the other lanes have no effect.
          if (w_strb_reg[0]) begin
            hold_reg <= w_data_reg[`AIR_CTRL_HOLD_BIT];
          end
        end else if (aw_addr_reg == `AIR_STATUS_ADDR) begin
          // Status is read only; the write is ignored but accepted.
          s_axi_bresp <= `AXI_RESP_OKAY;
        end else begin
          s_axi_bresp <= `AXI_RESP_DECERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        // The master took the response; both channels open again next cycle.
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Status word gathering role, lines, attach, fault and the driven outputs.
  // Bits above the output field read as zero. The view is live: it follows the
  // synchronised pins and the registered outputs.
  wire [31:0] status_word;
  assign status_word = {
    10'h000,
    high_current_ind_n_oe, medium_current_ind_n_oe, default_current_ind_n_oe,
    connected_n_oe, cable_power_cc2_n_oe, cable_power_cc1_n_oe,
    plug_orientation_n_oe, audio_adapter, vbus_supply_enable, fault_latched_out,
    fault_now, fault_reg,
    (upstream_reg ? 1'b0 : dn_flipped),
    (upstream_reg ? up_attached : dn_attached),
    cc2_s, cc1_s, profile_s, role_ok_reg, upstream_reg
  };

  // AXI4-Lite read path: one read at a time, answered the cycle after it is taken.
  // Reads have no side effect, so the status word may be polled freely.
  assign s_axi_arready = !s_axi_rvalid;

  // Decode the read address and hold the answer until the master takes it.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `AXI_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      // Answer the address just taken; the data stands until the master takes it.
      s_axi_rvalid <= 1'b1;
      case (s_axi_araddr[`AIR_ADDR_W-1:0])
        `AIR_CTRL_ADDR: begin
          s_axi_rdata <= {31'h0000_0000, hold_reg};
          s_axi_rresp <= `AXI_RESP_OKAY;
        end
        `AIR_STATUS_ADDR: begin
          s_axi_rdata <= status_word;
          s_axi_rresp <= `AXI_RESP_OKAY;
        end
        default: begin
          // Unmapped words answer with a decode error and zero data.
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `AXI_RESP_DECERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      // Handshake done; arready rises again with rvalid low.
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // typec_attach_indicator_outputs

// ---- attach_indicator_regs.vh ----
// Constants for the Type-C attach indicator block: register map, fields and encodings.
`ifndef ATTACH_INDICATOR_REGS_VH
`define ATTACH_INDICATOR_REGS_VH

// Byte addresses of the software registers.
`define AIR_CTRL_ADDR        4'h0
`define AIR_STATUS_ADDR      4'h4
// Address bits decoded by the slave.
`define AIR_ADDR_W           4

// Packed pin synchroniser word: width and idle pattern (enable low, fault input high).
`define AIR_PIN_W            11
`define AIR_PIN_IDLE         11'h200

// Control register fields and reset value.
`define AIR_CTRL_HOLD_BIT    0
`define AIR_CTRL_RESET       1'h0

// Status register field positions.
`define AIR_ST_ROLE_BIT      0
`define AIR_ST_ROLE_OK_BIT   1
`define AIR_ST_PROF_LSB      2
`define AIR_ST_CC1_LSB       4
`define AIR_ST_CC2_LSB       6
`define AIR_ST_ATTACH_BIT    8
`define AIR_ST_FLIP_BIT      9
`define AIR_ST_FAULT_BIT     10
`define AIR_ST_FAULTNOW_BIT  11
`define AIR_ST_OUT_LSB       12
`define AIR_ST_OUT_W         10

// Per-line classification codes while acting as source (downstream role).
`define CC_OPEN              2'h0
`define CC_SINK_RD           2'h1
`define CC_CABLE_RA          2'h2

// Per-line classification codes while acting as sink (upstream role).
`define CC_ADV_NONE          2'h0
`define CC_ADV_DEFAULT       2'h1
`define CC_ADV_MEDIUM        2'h2
`define CC_ADV_HIGH          2'h3

// Profile select codes; the last one selects the upstream role.
`define PROF_UPSTREAM        2'h3

// Settling cycles before the profile level is latched after reset.
`define AIR_SETTLE_CYCLES    2'h3

// AXI response codes.
`define AXI_RESP_OKAY        2'h0
`define AXI_RESP_SLVERR      2'h2
`define AXI_RESP_DECERR      2'h3

`endif

// ---- pin_sync.v ----
// Two flip-flop synchroniser for a bus of asynchronous pin levels.
`timescale 1ns/1ns
module pin_sync #(
  parameter WIDTH = 1
) (
  input  wire             aclk,
  input  wire             aresetn,
  input  wire [WIDTH-1:0] async_in,
  input  wire [WIDTH-1:0] reset_value,
  output wire [WIDTH-1:0] sync_out
);

  // Each bit gets its own pair of flops; the first flop feeds only the second.
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg meta_reg;  // First stage, may go metastable.
      reg safe_reg;  // Second stage, safe to read.
      // Reset loads constant idle levels chosen by the instantiating module.
      always @(posedge aclk) begin
        if (!aresetn) begin
          meta_reg <= reset_value[i];
          safe_reg <= reset_value[i];
        end else begin
          meta_reg <= async_in[i];
          safe_reg <= meta_reg;
        end
      end
      assign sync_out[i] = safe_reg;
    end
  endgenerate

endmodule // pin_sync

// ---- attach_ind_chk.sv ----
// Concurrent checks on the attach indicator pins.
`timescale 1ns/1ns
`include "attach_indicator_regs.vh"
module attach_ind_chk (
  input wire       aclk,
  input wire       aresetn,
  input wire       enable,
  input wire       overcurrent_in_n,
  input wire       vbus_level_monitor,
  input wire [1:0] cc1_class,
  input wire [1:0] cc2_class,
  input wire       vbus_supply_enable,
  input wire       audio_adapter,
  input wire       fault_latched_out,
  input wire       plug_orientation_n_oe,
  input wire       cable_power_cc1_n_oe,
  input wire       cable_power_cc2_n_oe,
  input wire       connected_n_oe,
  input wire       default_current_ind_n_oe,
  input wire       medium_current_ind_n_oe,
  input wire       high_current_ind_n_oe
);
  // Any source-role output active.
  wire       ds  = vbus_supply_enable | audio_adapter | plug_orientation_n_oe
                 | cable_power_cc1_n_oe | cable_power_cc2_n_oe;
  // The three capability indicators.
  wire [2:0] cap = {default_current_ind_n_oe, medium_current_ind_n_oe, high_current_ind_n_oe};
  // Any sink-role output active.
  wire       us  = connected_n_oe | (|cap);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_role_exclusive: assert property (!(ds && us))
    else $error("outputs of both roles active");
  a_cap_onehot: assert property ($onehot0(cap) && (!(|cap) || connected_n_oe))
    else $error("capability indicators inconsistent");
  a_vbus_attach: assert property (vbus_supply_enable |->
    (($past(cc1_class, 3) == `CC_SINK_RD) != ($past(cc2_class, 3) == `CC_SINK_RD)))
    else $error("supply enabled without one sink line");
  a_orient_cc1: assert property (
    (cc1_class == `CC_SINK_RD && cc2_class != `CC_SINK_RD) [*4] |-> !plug_orientation_n_oe)
    else $error("orientation asserted with sink on first line");
  a_orient_cc2: assert property (plug_orientation_n_oe |->
    $past(cc2_class, 3) == `CC_SINK_RD && vbus_supply_enable)
    else $error("orientation asserted without sink on second line");
  a_power_cc1: assert property (cable_power_cc1_n_oe |->
    $past(cc1_class, 3) == `CC_CABLE_RA && $past(cc2_class, 3) == `CC_SINK_RD)
    else $error("first line cable power without cable");
  a_power_cc2: assert property (cable_power_cc2_n_oe |->
    $past(cc2_class, 3) == `CC_CABLE_RA && $past(cc1_class, 3) == `CC_SINK_RD)
    else $error("second line cable power without cable");
  a_audio_both: assert property (audio_adapter |->
    $past(cc1_class, 3) == `CC_CABLE_RA && $past(cc2_class, 3) == `CC_CABLE_RA)
    else $error("audio output without audio accessory");
  a_overcurrent_off: assert property ((!overcurrent_in_n) [*4] |->
    fault_latched_out && !ds && !us)
    else $error("overcurrent not forcing outputs off");
  a_enable_off: assert property ((!enable) [*4] |-> !ds && !us)
    else $error("outputs active while disabled");
  a_overvolt_off: assert property (vbus_level_monitor [*4] |->
    fault_latched_out && !ds && !us)
    else $error("overvoltage not handled");
  a_fault_clear: assert property ($fell(fault_latched_out) |->
    $past(enable, 4) != $past(enable, 5))
    else $error("fault flag cleared without enable toggle");
endmodule // attach_ind_chk
bind typec_attach_indicator_outputs attach_ind_chk chk_u (
  .aclk(aclk), .aresetn(aresetn), .enable(enable), .overcurrent_in_n(overcurrent_in_n),
  .vbus_level_monitor(vbus_level_monitor), .cc1_class(cc1_class), .cc2_class(cc2_class),
  .vbus_supply_enable(vbus_supply_enable), .audio_adapter(audio_adapter),
  .fault_latched_out(fault_latched_out), .plug_orientation_n_oe(plug_orientation_n_oe),
  .cable_power_cc1_n_oe(cable_power_cc1_n_oe), .cable_power_cc2_n_oe(cable_power_cc2_n_oe),
  .connected_n_oe(connected_n_oe), .default_current_ind_n_oe(default_current_ind_n_oe),
  .medium_current_ind_n_oe(medium_current_ind_n_oe),
  .high_current_ind_n_oe(high_current_ind_n_oe));

// ---- cable_model.sv ----
// Behavioural model of the cable or accessory seen on the two CC lines.
`timescale 1ns/1ns
module cable_model (
  input  wire       aclk,
  input  wire [3:0] kind,           // Upper two bits second line, lower two first line.
  input  wire       audio_adapter,
  output reg  [1:0] cc1_class,
  output reg  [1:0] cc2_class,
  output wire       usb_path_audio  // High while the data pair is steered to audio.
);
  // Both lines start open, as with nothing plugged in.
  initial {cc2_class, cc1_class} = 4'h0;
  // The terminations follow the requested attachment one edge later.
  always @(posedge aclk) begin
    {cc2_class, cc1_class} <= kind;
  end
  // The board switch on the data pair follows the audio output.
  assign usb_path_audio = audio_adapter;
endmodule // cable_model

// ---- typec_attach_indicator_outputs_bench.sv ----
// Self-checking bench of the Type-C attach indicator block.
`timescale 1ns/1ns
`include "attach_indicator_regs.vh"
// Compares a value with its expectation and counts the outcome.
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin errors++; \
  $display("FAIL %0t got %h expected %h", $time, (got), (exp)); end end
module typec_attach_indicator_outputs_bench;
  logic        aclk, aresetn, enable, oc_n, mon, vbus_valid;
  logic [1:0]  profile_sel, cc1, cc2, bresp, rresp;
  logic [3:0]  kind, wstrb;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, usb_path_audio;
  logic        vse, audio, fault, orient, c1, c2, conn, dflt, med, high;
  wire  [9:0]  outs = {vse, audio, fault, orient, c1, c2, conn, dflt, med, high};
  int          errors = 0, n_checks = 0;
  // Free-running system clock.
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  typec_attach_indicator_outputs dut_u (
    .aclk(aclk), .aresetn(aresetn), .enable(enable), .overcurrent_in_n(oc_n),
    .vbus_level_monitor(mon), .vbus_valid(vbus_valid), .profile_sel(profile_sel),
    .cc1_class(cc1), .cc2_class(cc2), .vbus_supply_enable(vse), .audio_adapter(audio),
    .fault_latched_out(fault), .plug_orientation_n_oe(orient), .cable_power_cc1_n_oe(c1),
    .cable_power_cc2_n_oe(c2), .connected_n_oe(conn), .default_current_ind_n_oe(dflt),
    .medium_current_ind_n_oe(med), .high_current_ind_n_oe(high),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  cable_model cable_u (.aclk(aclk), .kind(kind), .audio_adapter(audio), .cc1_class(cc1),
    .cc2_class(cc2), .usb_path_audio(usb_path_audio));
  // Sets attachment and pins {enable, oc_n, mon, vbus_valid}, waits, compares outputs.
  task automatic apply(input logic [3:0] k, input logic [3:0] p, input logic [9:0] e);
    kind <= k;
    {enable, oc_n, mon, vbus_valid} <= p;
    repeat (6) @(posedge aclk);
    `CHK(outs, e)
  endtask
  // Holds reset for four edges with the given profile, then lets the role latch.
  task automatic do_reset(input logic [1:0] prof);
    aresetn     <= 1'b0;
    profile_sel <= prof;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (8) @(posedge aclk);
  endtask
  // Offers address and data together and releases each once taken.
  task automatic axi_write(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
    bit pa = 1'b1, pw = 1'b1;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      pa = pa && !awready;
      pw = pw && !wready;
      if (!pa) awvalid <= 1'b0;
      if (!pw) wvalid <= 1'b0;
    end while (pa || pw);
    do @(posedge aclk); while (bvalid !== 1'b1);
    `CHK(bresp, r)
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  // Reads one word and compares data and response.
  task automatic axi_read(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    `CHK(rdata, d)
    `CHK(rresp, r)
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (5000) @(posedge aclk);
    errors++;
    wrap_up();
  end
  // Main sequence: source role, faults, registers, then sink role.
  initial begin
    {enable, oc_n, mon, vbus_valid} = 4'hc;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, wdata, araddr} = 96'h0;
    wstrb = 4'hf;
    kind = 4'h0;
    do_reset(2'h0);
    apply(4'h9, 4'hc, 10'h210);
    apply(4'h6, 4'hc, 10'h260);
    apply(4'h1, 4'hc, 10'h200);
    apply(4'h4, 4'hc, 10'h240);
    apply(4'hd, 4'hc, 10'h200);
    apply(4'h5, 4'hc, 10'h000);
    apply(4'ha, 4'hc, 10'h100);
    `CHK(usb_path_audio, 1'b1)
    apply(4'h0, 4'hc, 10'h000);
    apply(4'h9, 4'h8, 10'h080);
    apply(4'h9, 4'hc, 10'h290);
    apply(4'h9, 4'h4, 10'h000);
    apply(4'h9, 4'hc, 10'h210);
    apply(4'h9, 4'he, 10'h080);
    apply(4'h9, 4'hc, 10'h290);
    apply(4'h9, 4'h4, 10'h000);
    apply(4'h9, 4'hc, 10'h210);
    // Register view: reset value, snapshot, hold, read-only and unmapped places.
    axi_read(32'h0, 32'h0, `AXI_RESP_OKAY);
    axi_read(32'h4, 32'h00022192, `AXI_RESP_OKAY);
    axi_write(32'h0, 32'h1, `AXI_RESP_OKAY);
    apply(4'h9, 4'hc, 10'h000);
    axi_read(32'h0, 32'h1, `AXI_RESP_OKAY);
    axi_write(32'h4, 32'hffffffff, `AXI_RESP_OKAY);
    axi_write(32'h8, 32'h1, `AXI_RESP_DECERR);
    axi_read(32'h8, 32'h0, `AXI_RESP_DECERR);
    axi_write(32'h0, 32'h0, `AXI_RESP_OKAY);
    // A write without byte lane zero leaves the hold bit alone.
    wstrb <= 4'he;
    axi_write(32'h0, 32'h1, `AXI_RESP_OKAY);
    wstrb <= 4'hf;
    axi_read(32'h0, 32'h0, `AXI_RESP_OKAY);
    apply(4'h9, 4'hc, 10'h210);
    // Sink role after a second reset.
    do_reset(`PROF_UPSTREAM);
    apply(4'h1, 4'hd, 10'h00c);
    apply(4'h8, 4'hd, 10'h00a);
    apply(4'h3, 4'hd, 10'h009);
    apply(4'h5, 4'hd, 10'h000);
    apply(4'h1, 4'hc, 10'h000);
    profile_sel <= 2'h0;
    apply(4'h9, 4'hd, 10'h000);
    apply(4'h4, 4'hd, 10'h00c);
    wrap_up();
  end
endmodule // typec_attach_indicator_outputs_bench
